// File: ube_core.sv
// USB bus event flags, remote wake-up pulse and endpoint access flags behind APB
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "ube_map.svh"
// ===========================================================
module ube_core #(
  parameter int NUM_EP = 8
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire ube_pkg::ube_apb_req_s apb_req_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic bus_reset_i,
  input wire logic bus_suspend_i,
  input wire logic [7:0] ep_touch_i,
  output logic wakeup_pulse_o,
  output logic bus_reset_seen_o,
  output logic bus_suspend_seen_o,
  output logic usb_irq_o
);
  // ===========================================================
  // Constants
  localparam logic [7:0] EP_MASK = (NUM_EP >= 8) ? 8'hFF : ((NUM_EP == 6) ? 8'h3F : 8'h0F);
  localparam int WAKE_CYC = `UBE_WAKE_CYC;
  localparam logic [9:0] WAKE_LAST = 10'(WAKE_CYC - 1);

  // Address compare, shared by the write decodes and the mapped check; the read mux uses a case
  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] off);
    addr_is = (addr == off);
  endfunction : addr_is

  // ===========================================================
  // Input synchronisers; bus pins come from outside this domain
  logic [1:0] rst_sync_r, rst_sync_nxt;
  logic [1:0] bus_suspend_seen_sync_r, bus_suspend_seen_sync_nxt;
  logic [7:0] ep_s1_r, ep_s1_nxt, ep_s2_r, ep_s2_nxt;
  always_comb begin
    rst_sync_nxt = {rst_sync_r[0], bus_reset_i};
    bus_suspend_seen_sync_nxt = {bus_suspend_seen_sync_r[0], bus_suspend_i};
    ep_s1_nxt = ep_touch_i;
    ep_s2_nxt = ep_s1_r;
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_r <= 2'h0;
      bus_suspend_seen_sync_r <= 2'h0;
      ep_s1_r <= 8'h00;
      ep_s2_r <= 8'h00;
    end else begin
      rst_sync_r <= rst_sync_nxt;
      bus_suspend_seen_sync_r <= bus_suspend_seen_sync_nxt;
      ep_s1_r <= ep_s1_nxt;
      ep_s2_r <= ep_s2_nxt;
    end
  end

  // ===========================================================
  // APB decode
  logic acc_ok, wr_acc;
  logic [1:0] irq_wr;
  logic ready_r, ready_nxt, err_r, err_nxt;
  // Writes land only on the edge that completes the access, where pready_o
  // is high; the first access-phase edge only arms the answer, so a clear
  // or a wake command is never applied twice
  always_comb begin
    acc_ok = apb_req_i.psel && apb_req_i.penable;
    wr_acc = acc_ok && apb_req_i.pwrite && ready_r;
    irq_wr = apb_req_i.pwdata[`UBE_IRQ_WIDTH-1:0];
  end

  // ===========================================================
  // Event flags, interrupt status and mask
  logic rst_flag_r, rst_flag_nxt;
  logic bus_suspend_seen_flag_r, bus_suspend_seen_flag_nxt;
  logic [1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] ep_flag_r, ep_flag_nxt;
  always_comb begin
    // Flags follow the engine: set and cleared by hardware only
    rst_flag_nxt = rst_sync_r[1];
    bus_suspend_seen_flag_nxt = bus_suspend_seen_sync_r[1];
    irq_stat_nxt = irq_stat_r;
    irq_mask_nxt = irq_mask_r;
    if (wr_acc && addr_is(apb_req_i.paddr, `UBE_OFF_IRQ_STAT)) begin
      irq_stat_nxt = irq_stat_r & ~irq_wr;
    end
    if (wr_acc && addr_is(apb_req_i.paddr, `UBE_OFF_IRQ_MASK)) begin
      irq_mask_nxt = irq_wr;
    end
    // Set beats clear so an event never slips past a clear
    if (rst_flag_nxt && !rst_flag_r) begin
      irq_stat_nxt[1] = 1'b1;
    end
    if (bus_suspend_seen_flag_nxt && !bus_suspend_seen_flag_r) begin
      irq_stat_nxt[0] = 1'b1;
    end
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    // Endpoint flags: writable, sticky on access, unused bits stay zero
    ep_flag_nxt = ep_flag_r;
    if (wr_acc && addr_is(apb_req_i.paddr, `UBE_OFF_EPFLAG)) begin
      ep_flag_nxt = apb_req_i.pwdata[7:0];
    end
    ep_flag_nxt = (ep_flag_nxt | ep_s2_r) & EP_MASK;
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_flag_r <= 1'b0;
      bus_suspend_seen_flag_r <= 1'b0;
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
      irq_r <= 1'b0;
      ep_flag_r <= `UBE_EPFLAG_RESET;
    end else begin
      rst_flag_r <= rst_flag_nxt;
      bus_suspend_seen_flag_r <= bus_suspend_seen_flag_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r <= irq_nxt;
      ep_flag_r <= ep_flag_nxt;
    end
  end

  // ===========================================================
  // Remote wake-up pulse; a command during a pulse is ignored
  ube_pkg::ube_wake_e wake_st_r, wake_st_nxt;
  logic [9:0] wake_cnt_r, wake_cnt_nxt;
  logic wake_out_r, wake_out_nxt;
  logic wake_cmd;
  always_comb begin
    wake_cmd = wr_acc && addr_is(apb_req_i.paddr, `UBE_OFF_CTRL) && apb_req_i.pwdata[`UBE_BIT_WAKEUP];
    wake_st_nxt = wake_st_r;
    wake_cnt_nxt = wake_cnt_r;
    unique case (wake_st_r)
      ube_pkg::UBE_WAKE_IDLE: begin
        if (wake_cmd) begin
          wake_st_nxt = ube_pkg::UBE_WAKE_PULSE;
          wake_cnt_nxt = 10'h000;
        end
      end
      ube_pkg::UBE_WAKE_PULSE: begin
        if (wake_cnt_r == WAKE_LAST) begin
          wake_st_nxt = ube_pkg::UBE_WAKE_IDLE;
        end else begin
          wake_cnt_nxt = wake_cnt_r + 10'h001;
        end
      end
      default: begin
        wake_st_nxt = ube_pkg::UBE_WAKE_IDLE;
      end
    endcase
    wake_out_nxt = (wake_st_nxt == ube_pkg::UBE_WAKE_PULSE);
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_st_r <= ube_pkg::UBE_WAKE_IDLE;
      wake_cnt_r <= 10'h000;
      wake_out_r <= 1'b0;
    end else begin
      wake_st_r <= wake_st_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      wake_out_r <= wake_out_nxt;
    end
  end

  // ===========================================================
  // APB answer: one wait state, read data registered
  logic [31:0] rdata_r, rdata_nxt;
  logic mapped;
  always_comb begin
    mapped = addr_is(apb_req_i.paddr, `UBE_OFF_CTRL) || addr_is(apb_req_i.paddr, `UBE_OFF_EPFLAG) ||
             addr_is(apb_req_i.paddr, `UBE_OFF_IRQ_STAT) || addr_is(apb_req_i.paddr, `UBE_OFF_IRQ_MASK);
    ready_nxt = acc_ok && !ready_r;
    err_nxt = ready_nxt && !mapped;
    rdata_nxt = 32'h0000_0000;
    if (ready_nxt && !apb_req_i.pwrite) begin
      unique case (apb_req_i.paddr)
        `UBE_OFF_CTRL: rdata_nxt = {29'h0000_0000, rst_flag_r, wake_out_r, bus_suspend_seen_flag_r};
        `UBE_OFF_EPFLAG: rdata_nxt = {24'h00_0000, ep_flag_r};
        `UBE_OFF_IRQ_STAT: rdata_nxt = {30'h0000_0000, irq_stat_r};
        `UBE_OFF_IRQ_MASK: rdata_nxt = {30'h0000_0000, irq_mask_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ready_r <= ready_nxt;
      err_r <= err_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ===========================================================
  // Outputs are the registers themselves, no logic after the flops
  assign prdata_o = rdata_r;
  assign pready_o = ready_r;
  assign pslverr_o = err_r;
  assign wakeup_pulse_o = wake_out_r;
  assign bus_reset_seen_o = rst_flag_r;
  assign bus_suspend_seen_o = bus_suspend_seen_flag_r;
  assign usb_irq_o = irq_r;

  // ===========================================================
  // Pulse length meter for the width checks; a delay this long would
  // slow the tools badly, so the high cycles are counted instead
  logic [9:0] pulse_len_r, pulse_len_nxt;
  always_comb begin
    pulse_len_nxt = wake_out_r ? pulse_len_r + 10'h001 : 10'h000;
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pulse_len_r <= 10'h000;
    end else begin
      pulse_len_r <= pulse_len_nxt;
    end
  end

  // ===========================================================
  // Checks
  // Pulse ends after exactly the wake-up width
  wake_width_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $fell(wakeup_pulse_o) |-> pulse_len_r == 10'(WAKE_CYC))
    else $error("wake-up pulse width wrong");
  // Pulse never runs past the wake-up width
  wake_limit_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    wakeup_pulse_o |-> pulse_len_r < 10'(WAKE_CYC))
    else $error("wake-up pulse too long");
  // A command while idle starts the pulse on the next edge
  wake_start_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (wake_cmd && wake_st_r == ube_pkg::UBE_WAKE_IDLE) |=> wakeup_pulse_o)
    else $error("wake-up pulse did not start");
  // Pin mirrors the pulse state, so a glitch cannot escape
  wake_state_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    wakeup_pulse_o == (wake_st_r == ube_pkg::UBE_WAKE_PULSE))
    else $error("wake-up pin out of step with state");
  // Suspend flag drops once the bus leaves suspend
  bus_suspend_seen_clear_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !bus_suspend_seen_sync_r[1] |=> !bus_suspend_seen_o)
    else $error("suspend flag not cleared");
  // Bus reset rise records its status bit
  rst_stat_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(bus_reset_seen_o) |-> irq_stat_r[1])
    else $error("bus reset rise did not set status");
  // Interrupt line is the masked status, nothing more
  irq_level_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    usb_irq_o == |(irq_stat_r & irq_mask_r))
    else $error("interrupt level disagrees with status");
  // Four endpoint variant keeps its upper nibble at zero
  ep_four_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (NUM_EP == 4) |-> ep_flag_r[7:4] == 4'h0)
    else $error("four endpoint upper bits set");
  // Ready stands for a single cycle per access
  ready_pulse_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    pready_o |=> !pready_o)
    else $error("ready held too long");
  // Error is only ever shown with ready
  err_ready_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    pslverr_o |-> pready_o)
    else $error("error without ready");
  // Refused reads return zero
  err_data_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    pslverr_o |-> prdata_o == 32'h0000_0000)
    else $error("refused read returned data");
  bus_suspend_seen_follow_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    bus_suspend_seen_sync_r[1] |=> bus_suspend_seen_o)
    else $error("suspend flag not following bus");
  bus_suspend_seen_irq_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(bus_suspend_seen_o) |-> irq_stat_r[0])
    else $error("suspend rise did not set status");
  rst_irq_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ($rose(bus_reset_seen_o) && irq_mask_r[1]) |=> usb_irq_o)
    else $error("bus reset did not raise interrupt");
  rst_follow_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !rst_sync_r[1] |=> !bus_reset_seen_o)
    else $error("bus reset flag not cleared");
  ep_sticky_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (ep_s2_r[0] && !wr_acc) |=> ep_flag_r[0])
    else $error("endpoint flag not set");
  ep_upper_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (ep_flag_r & ~EP_MASK) == 8'h00)
    else $error("unimplemented endpoint bits set");
  ep_write_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (wr_acc && apb_req_i.paddr == `UBE_OFF_EPFLAG && !apb_req_i.pwdata[4] && !ep_s2_r[4]) |=> !ep_flag_r[4])
    else $error("endpoint 4 flag not writable");
endmodule : ube_core

// File: ube_map.svh
// Register map, field positions and timing counts of the USB bus event block
`ifndef UBE_MAP_SVH
`define UBE_MAP_SVH
`define UBE_OFF_CTRL 12'h000
`define UBE_OFF_EPFLAG 12'h004
`define UBE_OFF_IRQ_STAT 12'h008
`define UBE_OFF_IRQ_MASK 12'h00C
`define UBE_BIT_SUSPEND 0
`define UBE_BIT_WAKEUP 1
`define UBE_BIT_RESET 2
`define UBE_EPFLAG_RESET 8'h00
`define UBE_IRQ_WIDTH 2
`define UBE_WAKE_NS 4000
`define UBE_CLK_NS 8
`define UBE_WAKE_CYC ((`UBE_WAKE_NS + `UBE_CLK_NS - 1) / `UBE_CLK_NS)
`endif

// File: ube_pkg.sv
// Types shared by the USB bus event block
package ube_pkg;
  typedef enum logic [1:0] {
    UBE_WAKE_IDLE = 2'b01,
    UBE_WAKE_PULSE = 2'b10
  } ube_wake_e;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } ube_apb_req_s;
endpackage : ube_pkg

// File: ube_usb_host.sv
// Host side model: bus reset, suspend and endpoint traffic
`timescale 1ns/1ps
module ube_usb_host (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic reset_req_i,
  input wire logic suspend_req_i,
  input wire logic [7:0] touch_req_i,
  input wire logic wakeup_pulse_i,
  output logic bus_reset_o,
  output logic bus_suspend_o,
  output logic [7:0] ep_touch_o
);
  logic [7:0] touch_r;
  // ==========
  // Line state; a touch is stretched to two cycles, longer than the one cycle the engine needs
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_reset_o <= 1'b0;
      bus_suspend_o <= 1'b0;
      touch_r <= 8'h00;
      ep_touch_o <= 8'h00;
    end else begin
      bus_reset_o <= reset_req_i;
      if (wakeup_pulse_i) bus_suspend_o <= 1'b0;
      else if (suspend_req_i) bus_suspend_o <= 1'b1;
      touch_r <= touch_req_i;
      ep_touch_o <= touch_req_i | touch_r;
    end
  end
endmodule : ube_usb_host

// File: usb_bus_event_and_endpoint_flags_tb.sv
// Testbench of the USB bus event block, six endpoint variant
`timescale 1ns/1ps
`include "ube_map.svh"
module usb_bus_event_and_endpoint_flags_tb;
  localparam int WAKE_CYC = `UBE_WAKE_CYC;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  ube_pkg::ube_apb_req_s req = '0;
  logic rst_req = 1'b0, bus_suspend_seen_req = 1'b0;
  logic [7:0] tch = 8'h00;
  logic [7:0] ep_touch;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, bus_rst, bus_bus_suspend_seen, wake, rst_seen, bus_suspend_seen_seen, irq;
  int bad_count = 0, comparisons = 0, wake_cnt = 0;
  // Rows: endpoint touches and the flags they should leave
  logic [7:0] row_t [4] = '{8'h01, 8'h10, 8'hC0, 8'h2C};
  logic [7:0] row_e [4] = '{8'h01, 8'h11, 8'h11, 8'h3D};
  ube_core #(.NUM_EP(6)) uut (.core_clk_i(clk), .arst_n_i(arst_n), .apb_req_i(req),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .bus_reset_i(bus_rst),
    .bus_suspend_i(bus_bus_suspend_seen), .ep_touch_i(ep_touch), .wakeup_pulse_o(wake),
    .bus_reset_seen_o(rst_seen), .bus_suspend_seen_o(bus_suspend_seen_seen), .usb_irq_o(irq));
  ube_usb_host host (.core_clk_i(clk), .arst_n_i(arst_n), .reset_req_i(rst_req),
    .suspend_req_i(bus_suspend_seen_req), .touch_req_i(tch), .wakeup_pulse_i(wake),
    .bus_reset_o(bus_rst), .bus_suspend_o(bus_bus_suspend_seen), .ep_touch_o(ep_touch));
  // ==========
  // Clock and wake pulse width counter
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wake === 1'b1) wake_cnt++;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
  endtask : idle
  // One APB transfer; waits for pready under a bound, never a fixed count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    req.penable <= 1'b1;
    // Pready is read at each rising edge, before that edge's updates land
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      bad_count++;
      results();
    end
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  // ==========
  // Main sequence
  initial begin
    idle(16);
    arst_n <= 1'b1;
    apb(0, `UBE_OFF_EPFLAG, 0);
    chk("epflag_rst", rd, 0);
    for (int i = 0; i < 4; i++) begin
      tch <= row_t[i];
      idle(1);
      tch <= 8'h00;
      idle(6);
      apb(0, `UBE_OFF_EPFLAG, 0);
      chk("epflag", rd, {24'h00_0000, row_e[i]});
    end
    apb(1, `UBE_OFF_EPFLAG, 32'hFFFF_FFFF);
    apb(0, `UBE_OFF_EPFLAG, 0);
    chk("epflag_ones", rd, 32'h0000_003F);
    apb(1, `UBE_OFF_EPFLAG, 0);
    apb(0, `UBE_OFF_EPFLAG, 0);
    chk("epflag_zero", rd, 0);
    apb(1, `UBE_OFF_IRQ_MASK, 3);
    bus_suspend_seen_req <= 1'b1;
    idle(1);
    bus_suspend_seen_req <= 1'b0;
    idle(8);
    chk("bus_suspend_seen_seen", bus_suspend_seen_seen, 1);
    apb(0, `UBE_OFF_CTRL, 0);
    chk("ctrl_bus_suspend_seen", rd[0], 1);
    chk("irq_bus_suspend_seen", irq, 1);
    apb(0, `UBE_OFF_IRQ_STAT, 0);
    chk("stat_bus_suspend_seen", rd, 1);
    apb(1, `UBE_OFF_IRQ_STAT, 1);
    idle(2);
    chk("irq_clear", irq, 0);
    // Count starts before the command; a repeated command edge must not stretch it
    wake_cnt = 0;
    apb(1, `UBE_OFF_CTRL, 2);
    idle(100);
    apb(1, `UBE_OFF_CTRL, 2);
    idle(WAKE_CYC);
    chk("wake_width", wake_cnt, WAKE_CYC);
    idle(6);
    chk("bus_suspend_seen_left", bus_suspend_seen_seen, 0);
    rst_req <= 1'b1;
    idle(6);
    chk("rst_seen", rst_seen, 1);
    rst_req <= 1'b0;
    idle(6);
    chk("rst_gone", rst_seen, 0);
    apb(0, `UBE_OFF_IRQ_STAT, 0);
    chk("stat_rst", rd, 2);
    chk("irq_rst", irq, 1);
    apb(1, `UBE_OFF_IRQ_MASK, 0);
    idle(2);
    chk("irq_masked", irq, 0);
    apb(0, 12'h010, 0);
    chk("unmapped_err", err, 1);
    chk("unmapped_data", rd, 0);
    apb(1, `UBE_OFF_EPFLAG, 32'h0000_0001);
    arst_n <= 1'b0;
    idle(2);
    arst_n <= 1'b1;
    apb(0, `UBE_OFF_EPFLAG, 0);
    chk("epflag_rerst", rd, 0);
    results();
  end
endmodule : usb_bus_event_and_endpoint_flags_tb
